// [rsso_pkg.sv]
package rsso_pkg;

    // operation select codes
    typedef enum logic [2:0] {
        RSSO_OP_NONE   = 3'h0,
        RSSO_OP_ROTR   = 3'h1,
        RSSO_OP_ROTL   = 3'h2,
        RSSO_OP_LSUB   = 3'h3,
        RSSO_OP_RETK   = 3'h4,
        RSSO_OP_SLEEP  = 3'h5
    } rsso_op_t;

    // apb register offsets
    localparam logic [7:0] RSSO_OFS_CMD    = 8'h00;
    localparam logic [7:0] RSSO_OFS_ACCUM  = 8'h04;
    localparam logic [7:0] RSSO_OFS_STATUS = 8'h08;
    localparam logic [7:0] RSSO_OFS_FILE   = 8'h0c;
    localparam logic [7:0] RSSO_OFS_STACK  = 8'h10;
    localparam logic [7:0] RSSO_OFS_PC     = 8'h14;
    localparam logic [7:0] RSSO_OFS_WDOG   = 8'h18;

    // command word fields
    localparam int RSSO_CMD_OP_LSB   = 0;
    localparam int RSSO_CMD_DEST_BIT = 4;
    localparam int RSSO_CMD_K_LSB    = 8;

    // status field positions
    localparam int RSSO_ST_CARRY  = 0;
    localparam int RSSO_ST_DCARRY = 1;
    localparam int RSSO_ST_ZERO   = 2;
    localparam int RSSO_ST_PDN    = 3;
    localparam int RSSO_ST_TON    = 4;
    localparam int RSSO_ST_SLEEP  = 5;
    localparam int RSSO_ST_BUSY   = 6;

    // reset values
    localparam logic [7:0]  RSSO_RST_BYTE = 8'h00;
    localparam logic [12:0] RSSO_RST_PC   = 13'h0000;
    localparam logic        RSSO_RST_PDN  = 1'b1;
    localparam logic        RSSO_RST_TON  = 1'b1;

    // timing
    localparam int RSSO_RETK_CYCLES = 2;

    typedef struct packed {
        logic sleep;
        logic ton;
        logic pdn;
        logic zero;
        logic dcarry;
        logic carry;
    } rsso_status_t;

endpackage

// [rsso_core.sv]
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RQ1] right rotate shifts the file byte down via carry, only carry changes.
// [RQ2] right rotate writes the accumulator if dest is 0, the file byte if 1.
// [RQ3] subtract sets acc to k minus acc; carry, digit carry flag no borrow.
// [RQ4] power-down clears the watchdog counter and its prescaler.
// [RQ5] power-down clears powerdown, sets timeout, no other status bit moves; the core also sets the sleep status bit.
// [RQ6] power-down enters sleep with oscillator halted so execution stops.
// [RQ7] literal subtract sets zero when the result is zero, else clears it.
// [RQ8] return puts k in the accumulator, pops stack top to pc, two cycles.
// [RQ9] left rotate shifts the file byte up via carry, same dest select.
module rsso_core #(
    parameter int WDOG_WIDTH  = 8,
    parameter int PRESC_WIDTH = 8
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // core state
    output logic                   oscRun,
    output logic                   sleepActive
);
    import rsso_pkg::*;

    logic [7:0]          accum_q, accum_d;
    logic [7:0]          file_q, file_d;
    logic [12:0]         stack_q, stack_d;
    logic [12:0]         pc_q, pc_d;
    rsso_status_t        stat_q, stat_d;
    logic [WDOG_WIDTH-1:0]  wdog_q, wdog_d;
    logic [PRESC_WIDTH-1:0] presc_q, presc_d;
    logic                retkBusy_q, retkBusy_d;
    logic [7:0]          retkK_q, retkK_d;
    logic [31:0]         prdata_d;
    logic                pready_d, pslverr_d;

    logic                xfer;
    logic                cmdWr;
    rsso_op_t            op;
    logic                dest;
    logic [7:0]          kLit;
    logic [8:0]          diff;
    logic [4:0]          nibDiff;
    logic [7:0]          rot;

    // access phase sampled here is answered with pready one cycle later
    assign xfer  = psel && penable && !pready;
    assign cmdWr = xfer && pwrite && paddr == RSSO_OFS_CMD;
    assign op    = rsso_op_t'(pwdata[RSSO_CMD_OP_LSB +: 3]);
    assign dest  = pwdata[RSSO_CMD_DEST_BIT];
    assign kLit  = pwdata[RSSO_CMD_K_LSB +: 8];
    assign diff    = {1'b0, kLit} - {1'b0, accum_q};      // see [RQ3]
    assign nibDiff = {1'b0, kLit[3:0]} - {1'b0, accum_q[3:0]};

    always_comb begin
        accum_d    = accum_q;
        file_d     = file_q;
        stack_d    = stack_q;
        pc_d       = pc_q;
        stat_d     = stat_q;
        wdog_d     = wdog_q;
        presc_d    = presc_q + 1'b1;
        retkBusy_d = 1'b0;
        retkK_d    = retkK_q;
        rot        = 8'h00;
        // prescaler divides the core clock ahead of the watchdog;
        // both freeze with the oscillator, so sleep holds them at zero
        if (stat_q.ton == 1'b0 || sleepActive) begin
            presc_d = presc_q;
        end else if (&presc_q) begin
            wdog_d = wdog_q + 1'b1;
        end
        if (retkBusy_q) begin
            // second cycle of the return completes it; no bus write can
            // be taken here, since pready is high in this cycle
            accum_d = retkK_q;                            // see [RQ8]
            pc_d    = stack_q;                            // see [RQ8]
        end else if (cmdWr && !sleepActive) begin
            unique case (op)
                RSSO_OP_ROTR: begin
                    rot          = {stat_q.carry, file_q[7:1]}; // see [RQ1]
                    stat_d.carry = file_q[0];             // see [RQ1]
                    if (dest) begin
                        file_d = rot;                     // see [RQ2]
                    end else begin
                        accum_d = rot;                    // see [RQ2]
                    end
                end
                RSSO_OP_ROTL: begin
                    rot          = {file_q[6:0], stat_q.carry}; // see [RQ9]
                    stat_d.carry = file_q[7];             // see [RQ9]
                    if (dest) begin
                        file_d = rot;                     // see [RQ9]
                    end else begin
                        accum_d = rot;
                    end
                end
                RSSO_OP_LSUB: begin
                    accum_d       = diff[7:0];            // see [RQ3]
                    stat_d.carry  = ~diff[8];             // see [RQ3]
                    stat_d.dcarry = ~nibDiff[4];          // see [RQ3]
                    stat_d.zero   = diff[7:0] == 8'h00;   // see [RQ7]
                end
                RSSO_OP_RETK: begin
                    retkBusy_d = 1'b1;                    // see [RQ8]
                    retkK_d    = kLit;
                end
                RSSO_OP_SLEEP: begin
                    wdog_d     = '0;                      // see [RQ4]
                    presc_d    = '0;                      // see [RQ4]
                    stat_d.pdn = 1'b0;                    // see [RQ5]
                    stat_d.ton = 1'b1;                    // see [RQ5]
                    stat_d.sleep = 1'b1;                  // see [RQ6]
                end
                default: begin
                end
            endcase
        end else if (xfer && pwrite && !sleepActive) begin
            unique case (paddr)
                RSSO_OFS_ACCUM: accum_d = pwdata[7:0];
                RSSO_OFS_FILE:  file_d  = pwdata[7:0];
                RSSO_OFS_STACK: stack_d = pwdata[12:0];
                RSSO_OFS_STATUS,
                RSSO_OFS_PC,
                RSSO_OFS_WDOG: begin
                    // read-only: write accepted without effect
                end
                default: begin
                end
            endcase
        end
    end

    // sleep and oscillator state; only a reset wakes the core here
    // halting the oscillator also freezes the prescaler and watchdog
    logic sleep_d, osc_d;
    always_comb begin
        sleep_d = sleepActive;
        osc_d   = oscRun;
        if (cmdWr && !sleepActive && !retkBusy_q && op == RSSO_OP_SLEEP) begin
            sleep_d = 1'b1;                               // see [RQ6]
            osc_d   = 1'b0;                               // see [RQ6]
        end
    end

    // apb answer: one wait cycle, unmapped offsets give an error
    // unaligned offsets fall to the default and raise the error too
    always_comb begin
        pready_d  = xfer;
        pslverr_d = 1'b0;
        prdata_d  = 32'h0000_0000;
        if (xfer) begin
            unique case (paddr)
                RSSO_OFS_CMD:    prdata_d = {31'h0, retkBusy_q};
                RSSO_OFS_ACCUM:  prdata_d = {24'h0, accum_q};
                RSSO_OFS_STATUS: prdata_d = {25'h0, retkBusy_q, stat_q.sleep,
                                             stat_q.ton, stat_q.pdn,
                                             stat_q.zero, stat_q.dcarry,
                                             stat_q.carry};
                RSSO_OFS_FILE:   prdata_d = {24'h0, file_q};
                RSSO_OFS_STACK:  prdata_d = {19'h0, stack_q};
                RSSO_OFS_PC:     prdata_d = {19'h0, pc_q};
                RSSO_OFS_WDOG:   prdata_d = {16'h0, 8'(presc_q), 8'(wdog_q)};
                default:         pslverr_d = 1'b1;
            endcase
            // command issued while asleep or while the return is in flight is refused
            if (pwrite && paddr == RSSO_OFS_CMD
                    && (retkBusy_q || sleepActive)) begin
                pslverr_d = 1'b1;
            end
        end
    end

    // one register stage for all state, so every output leaves a flop
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            accum_q     <= RSSO_RST_BYTE;
            file_q      <= RSSO_RST_BYTE;
            stack_q     <= RSSO_RST_PC;
            pc_q        <= RSSO_RST_PC;
            stat_q      <= '{sleep: 1'b0, ton: RSSO_RST_TON,
                             pdn: RSSO_RST_PDN, zero: 1'b0,
                             dcarry: 1'b0, carry: 1'b0};
            wdog_q      <= '0;
            presc_q     <= '0;
            retkBusy_q  <= 1'b0;
            retkK_q     <= RSSO_RST_BYTE;
            sleepActive <= 1'b0;
            oscRun      <= 1'b1;
            prdata      <= 32'h0000_0000;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
        end else begin
            accum_q     <= accum_d;
            file_q      <= file_d;
            stack_q     <= stack_d;
            pc_q        <= pc_d;
            stat_q      <= stat_d;
            wdog_q      <= wdog_d;
            presc_q     <= presc_d;
            retkBusy_q  <= retkBusy_d;
            retkK_q     <= retkK_d;
            sleepActive <= sleep_d;
            oscRun      <= osc_d;
            prdata      <= prdata_d;
            pready      <= pready_d;
            pslverr     <= pslverr_d;
        end
    end

endmodule
`default_nettype wire

// [rsso_core_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module rsso_core_chk
    import rsso_pkg::*;
(
    // clock and reset
    input wire logic        core_clk,
    input wire logic        sys_rst,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // core state
    input wire logic        oscRun,
    input wire logic        sleepActive
);
    logic take;
    logic cmdWr;
    logic rdNow;
    assign take = psel & penable & ~pready;
    assign cmdWr = take & pwrite & (paddr == RSSO_OFS_CMD);
    assign rdNow = pready & ~pwrite & sleepActive;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_ready_next: assert property (take |=> pready) else $error("late");
    a_ready_pulse: assert property (pready |=> !pready) else $error("long");
    a_err_unmapped: assert property (take && paddr > 8'h18 |=> pslverr)
        else $error("no error on unmapped");
    a_sleep_enter: assert property (
        cmdWr && pwdata[2:0] == 3'h5 && !sleepActive
        |=> sleepActive || pslverr) else $error("no sleep");
    a_sleep_holds: assert property (sleepActive |=> sleepActive)
        else $error("woke");
    a_osc_stop: assert property (sleepActive |-> !oscRun)
        else $error("osc runs asleep");
    a_cmd_asleep: assert property (
        cmdWr && sleepActive |=> pslverr) else $error("cmd taken asleep");
    a_wdog_clear: assert property (
        rdNow && paddr == RSSO_OFS_WDOG |-> prdata[15:0] == 16'h0)
        else $error("watchdog not clear");
    a_flags_sleep: assert property (
        rdNow && paddr == RSSO_OFS_STATUS |-> !prdata[3] && prdata[4])
        else $error("flags wrong");
endmodule
bind rsso_core rsso_core_chk rsso_core_chk_i (.core_clk(core_clk),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .oscRun(oscRun), .sleepActive(sleepActive));
`default_nettype wire

// [rotate_subtract_sleep_ops_test.sv]
`timescale 1ns/1ps
`default_nettype none
module rotate_subtract_sleep_ops_test;
    import rsso_pkg::*;
    logic        core_clk, sys_rst, psel, penable, pwrite, er;
    logic        pready, pslverr, oscRun, sleepActive;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    int          mismatches, n_compared, acc, fil, cy, dc, zf, k, op, ds, r;
    rsso_core rsso_core_i (.core_clk(core_clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .oscRun(oscRun), .sleepActive(sleepActive));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // master holds everything until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1 && ++n < 50);
        if (n >= 50) mismatches++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        #500000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        {sys_rst, psel, penable, pwrite, paddr, pwdata} = 44'h0;
        seed = 32'h35e5;
        sys_rst = 1'b1;
        {acc, fil, cy, dc, zf} = 160'h0;
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        apb(1'b0, RSSO_OFS_STATUS, 32'h0);
        chk("status rst", 32'h18, rd);
        for (int i = 0; i < 45; i++) begin
            op = i % 3 + 1;
            ds = xs() & 1;
            k = xs() & 255;
            acc = xs() & 255;
            fil = xs() & 255;
            apb(1'b1, RSSO_OFS_ACCUM, 32'(acc));
            apb(1'b1, RSSO_OFS_FILE, 32'(fil));
            apb(1'b1, RSSO_OFS_CMD, 32'((k << 8) | (ds << 4) | op));
            if (op == 1) begin
                r = (cy << 7) | (fil >> 1);
                cy = fil & 1;
            end else if (op == 2) begin
                r = ((fil << 1) & 255) | cy;
                cy = fil >> 7;
            end else begin
                r = (k - acc) & 255;
                cy = acc <= k;
                dc = (acc & 15) <= (k & 15);
                zf = r == 0;
                ds = 0;
            end
            if (ds == 1) fil = r;
            else acc = r;
            apb(1'b0, RSSO_OFS_ACCUM, 32'h0);
            chk("accum", 32'(acc), rd);
            apb(1'b0, RSSO_OFS_FILE, 32'h0);
            chk("file", 32'(fil), rd);
            apb(1'b0, RSSO_OFS_STATUS, 32'h0);
            chk("status", 32'(24|zf<<2|dc<<1|cy), rd);
        end
        r = xs() & 32'h1fff;
        acc = xs() & 255;
        apb(1'b1, RSSO_OFS_STACK, 32'(r));
        apb(1'b1, RSSO_OFS_CMD, 32'((acc << 8) | 4));
        apb(1'b0, RSSO_OFS_PC, 32'h0);
        chk("pc", 32'(r), rd);
        apb(1'b0, RSSO_OFS_ACCUM, 32'h0);
        chk("ret accum", 32'(acc), rd);
        apb(1'b0, 8'h1c, 32'h0);
        chk("unmapped", 32'h1, 32'(er));
        apb(1'b1, RSSO_OFS_CMD, 32'h5);
        chk("osc sleep", 32'h1, {oscRun, sleepActive});
        apb(1'b0, RSSO_OFS_STATUS, 32'h0);
        chk("status sleep", 32'(48|zf<<2|dc<<1|cy), rd);
        apb(1'b0, RSSO_OFS_WDOG, 32'h0);
        chk("wdog", 32'h0, rd);
        apb(1'b1, RSSO_OFS_CMD, 32'h1);
        chk("cmd asleep", 32'h1, 32'(er));
        report_and_stop();
    end
endmodule
`default_nettype wire
